/* File: inc/fpc_pkg.sv */
// Shared constants and types of the parallel flash host controller
package fpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 18; // Address inputs
	localparam int DATA_W = 8; // Data lines
	localparam int US_W = 14; // Microsecond timer width

	////////////////////////////////////////////////////////////////////////
	// Command bytes written to the flash
	localparam logic [7:0] CMD_READ = 8'h00; // Set read
	localparam logic [7:0] CMD_SIG = 8'h90; // Identification
	localparam logic [7:0] CMD_ERASE = 8'h20; // Erase, sent twice
	localparam logic [7:0] CMD_EVFY = 8'ha0; // Erase verify
	localparam logic [7:0] CMD_PROG = 8'h40; // Program
	localparam logic [7:0] CMD_PVFY = 8'hc0; // Program verify
	localparam logic [7:0] CMD_RESET = 8'hff; // Reset, sent twice
	localparam logic [7:0] BYTE_ERASED = 8'hff; // Erased byte
	localparam logic [7:0] BYTE_PREPROG = 8'h00; // Pre-erase fill

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_NS = 100; // Clock period
	localparam int US_NS = 1000; // One microsecond
	localparam int TICK_CYC = US_NS / CLK_NS; // Cycles per us tick
	localparam int T_PROG_US = 10; // Program interval
	localparam int T_RCV_US = 6; // Write recovery before read
	localparam int T_ERASE_US = 9500; // Erase pulse, 9.5 ms
	localparam int PROG_LOOPS = 25; // Program attempts per byte
	localparam int ERASE_LOOPS = 1000; // Erase attempts per chip
	localparam logic [2:0] WR_LAST = 3'h2; // Last phase of a write
	localparam logic [2:0] RD_LAST = 3'h4; // Last phase of a read

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		OP_READ, OP_SIG, OP_PROG, OP_ERASE, OP_ABORT
	} fpc_op_t;

	typedef struct packed {
		fpc_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fpc_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic fail;
	} fpc_rsp_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic dq_oe_n;
	} fpc_pins_t;

	// All strobes high, data lines released
	localparam fpc_pins_t PINS_IDLE = fpc_pins_t'({3'h7, 18'h00000, 8'h00, 1'b1});

endpackage

/* File: core/fpc_us_timer.sv */
// Microsecond wait timer with its own tick divider
`timescale 1ns/10ps
module fpc_us_timer #(
	parameter int CNT_W = fpc_pkg::US_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [CNT_W-1:0] load_us,
	output logic done
);
	import fpc_pkg::*;

	localparam int DIV_W = $clog2(TICK_CYC);
	localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(TICK_CYC - 1);

	logic [DIV_W-1:0] div_q; // Cycle within current microsecond
	logic [CNT_W-1:0] left_q; // Microseconds still to run
	logic run_q; // Wait in progress
	logic tick; // One-cycle microsecond enable

	assign tick = run_q && (div_q == DIV_TOP);

	////////////////////////////////////////////////////////////////////////
	// Divider restarts with each wait, so no wait comes out short
	always_ff @(posedge clk) begin
		if (!rstn || start || tick) begin
			div_q <= '0;
		end else if (run_q) begin
			div_q <= div_q + 1'b1;
		end
	end

	// Count down whole microseconds; load of zero is treated as one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			run_q <= 1'b0;
			left_q <= '0;
		end else if (start) begin
			run_q <= 1'b1;
			left_q <= load_us;
		end else if (tick) begin
			left_q <= left_q - 1'b1;
			if (left_q <= CNT_W'(1)) begin
				run_q <= 1'b0;
			end
		end
	end

	// Done pulse one edge after the last tick
	always_ff @(posedge clk) begin
		if (!rstn) begin
			done <= 1'b0;
		end else begin
			done <= tick && (left_q <= CNT_W'(1));
		end
	end

endmodule // fpc_us_timer

/* File: core/fpc_bus_cycle.sv */
// One flash bus cycle, write or read, on the strobe pins
`timescale 1ns/10ps
module fpc_bus_cycle (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic wr,
	input wire logic [fpc_pkg::ADDR_W-1:0] addr,
	input wire logic [fpc_pkg::DATA_W-1:0] wdata,
	input wire logic [fpc_pkg::DATA_W-1:0] dq_i,
	output fpc_pkg::fpc_pins_t pins,
	output logic [fpc_pkg::DATA_W-1:0] rdata,
	output logic done
);
	import fpc_pkg::*;

	logic act_q; // Cycle in progress
	logic wr_q; // Current cycle writes
	logic [2:0] ph_q; // Phase counter
	logic [DATA_W-1:0] dq_m_q; // First sync stage, read by dq_s_q only
	logic [DATA_W-1:0] dq_s_q; // Second sync stage
	logic last; // Final phase of the cycle

	assign last = act_q && (ph_q == (wr_q ? WR_LAST : RD_LAST));

	////////////////////////////////////////////////////////////////////////
	// Data lines come from outside the clock domain
	always_ff @(posedge clk) begin
		dq_m_q <= dq_i;
		dq_s_q <= dq_m_q;
	end

	// Phase sequencing
	always_ff @(posedge clk) begin
		if (!rstn) begin
			act_q <= 1'b0;
			wr_q <= 1'b0;
			ph_q <= 3'h0;
		end else if (start) begin
			act_q <= 1'b1;
			wr_q <= wr;
			ph_q <= 3'h0;
		end else if (act_q) begin
			ph_q <= ph_q + 3'h1;
			if (last) begin
				act_q <= 1'b0;
			end
		end
	end

	// Pin drive: address and data stay put across the strobe edges
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pins <= PINS_IDLE;
		end else if (start) begin
			// Read: chip select and output drive low, strobe high
			pins.ce_n <= 1'b0;
			pins.oe_n <= wr;
			pins.we_n <= 1'b1;
			pins.addr <= addr;
			pins.dq_o <= wdata;
			pins.dq_oe_n <= !wr;
		end else if (last) begin
			// Release ends standby-safe: outputs floated by chip select high
			pins.ce_n <= 1'b1;
			pins.oe_n <= 1'b1;
			pins.we_n <= 1'b1;
			pins.dq_oe_n <= 1'b1;
		end else if (act_q && wr_q) begin
			// Strobe low one phase; its rise latches the command byte
			pins.we_n <= (ph_q != 3'h0);
		end
	end

	// Read data is taken after the access time plus two sync stages
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= '0;
			done <= 1'b0;
		end else begin
			done <= last;
			if (last && !wr_q) begin
				rdata <= dq_s_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_drive_safe;
		@(posedge clk) disable iff (!rstn) !pins.dq_oe_n |-> pins.oe_n && !pins.ce_n;
	endproperty
	a_drive_safe: assert property (p_drive_safe) else $error("data driven with oe low");

	property p_read_pins;
		@(posedge clk) disable iff (!rstn) !pins.oe_n |-> !pins.ce_n && pins.we_n;
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("bad read strobes");

	sequence s_we_fall;
		$fell(pins.we_n) && !pins.dq_oe_n;
	endsequence
	property p_we_pulse;
		@(posedge clk) disable iff (!rstn)
			s_we_fall |=> $rose(pins.we_n) && !pins.dq_oe_n ##1 pins.ce_n && pins.dq_oe_n;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("bad write pulse");

endmodule // fpc_bus_cycle

/* File: core/fpc_ctrl.sv */
// Host controller that drives a byte-wide parallel flash through its pins
//
// Function
// - Read with select, drive low, strobe high
// - Send set-read before reads while supply high
// - Commands take one or two bus cycles
// - Command 00H selects array read
// - Command 90H gives maker, part codes
// - Erase is 20H twice, then erase starts
// - A0H with address, next read verifies it
// - 40H, then address and data write
// - C0H, next read returns programmed byte
// - Reset is FFH written twice
// - Wait 10 us plus 6 us; 25 tries
// - Program all bytes 00H before erase
`timescale 1ns/10ps
module fpc_ctrl #(
	parameter int ERASE_US = fpc_pkg::T_ERASE_US,
	parameter logic [fpc_pkg::ADDR_W-1:0] LAST_ADDR = 18'h3ffff,
	parameter int MAX_ERASE = fpc_pkg::ERASE_LOOPS
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic req_valid,
	output logic req_ready,
	input wire fpc_pkg::fpc_req_t req,
	output logic rsp_valid,
	output fpc_pkg::fpc_rsp_t rsp,
	output fpc_pkg::fpc_pins_t pins,
	input wire logic [fpc_pkg::DATA_W-1:0] dq_i,
	output logic program_supply_high
);
	import fpc_pkg::*;

	localparam int PROG_CYC = T_PROG_US * TICK_CYC; // Cycles of a program wait

	typedef enum logic [4:0] {
		S_IDLE, S_RD, S_VUP, S_SIG_CMD, S_SIG_RD,
		S_P_CMD, S_P_DAT, S_P_WT, S_P_VCMD, S_P_RCV, S_P_RD, S_P_CHK,
		S_E_CMD1, S_E_CMD2, S_E_WT, S_E_VCMD, S_E_RCV, S_E_RD, S_E_CHK,
		S_A1, S_A2, S_EXIT, S_FIN
	} fpc_state_t;

	fpc_state_t st_q; // Sequencer state
	fpc_op_t op_q; // Operation being run
	logic [ADDR_W-1:0] addr_q; // Current flash address
	logic [DATA_W-1:0] dat_q; // Byte to program
	logic [4:0] ploop_q; // Program attempts on this byte
	logic [9:0] eloop_q; // Erase pulses so far
	logic fail_q; // Attempt limit reached
	logic pend_q; // Bus cycle or wait outstanding
	logic vpp_q; // Program supply raised
	logic [16:0] wcnt_q; // Cycles spent in the current wait

	logic bus_wr; // State performs a write cycle
	logic bus_rd; // State performs a read cycle
	logic wt; // State waits on the timer
	logic [DATA_W-1:0] wbyte; // Byte for the write cycle
	logic [US_W-1:0] load_us; // Wait length
	logic bus_start; // Launch a bus cycle
	logic tim_start; // Launch a wait
	logic cyc_done; // Bus cycle finished
	logic tim_done; // Wait finished
	logic step; // Current state's work is complete
	logic [DATA_W-1:0] rd_data; // Last byte read
	logic rd_ok; // Read byte matches the target
	logic at_last; // Address at end of array

	////////////////////////////////////////////////////////////////////////
	// Per-state bus work
	always_comb begin
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		wt = 1'b0;
		wbyte = CMD_READ;
		load_us = '0;
		unique case (st_q)
			// Array, identification and verify reads
			S_RD, S_SIG_RD, S_P_RD, S_E_RD: begin
				bus_rd = 1'b1;
			end
			S_SIG_CMD: begin
				bus_wr = 1'b1;
				wbyte = CMD_SIG;
			end
			S_P_CMD: begin
				bus_wr = 1'b1;
				wbyte = CMD_PROG;
			end
			S_P_DAT: begin
				bus_wr = 1'b1;
				wbyte = dat_q;
			end
			S_P_VCMD: begin
				bus_wr = 1'b1;
				wbyte = CMD_PVFY;
			end
			S_E_CMD1, S_E_CMD2: begin
				bus_wr = 1'b1;
				wbyte = CMD_ERASE;
			end
			S_E_VCMD: begin
				bus_wr = 1'b1;
				wbyte = CMD_EVFY;
			end
			S_A1, S_A2: begin
				bus_wr = 1'b1;
				wbyte = CMD_RESET;
			end
			S_EXIT: begin
				// Back to array read before supply drops
				bus_wr = 1'b1;
				wbyte = CMD_READ;
			end
			// Flash times its own pulse; host only waits it out
			S_P_WT: begin
				wt = 1'b1;
				load_us = US_W'(T_PROG_US);
			end
			S_P_RCV, S_E_RCV: begin
				wt = 1'b1;
				load_us = US_W'(T_RCV_US);
			end
			S_E_WT: begin
				wt = 1'b1;
				load_us = US_W'(ERASE_US);
			end
			S_IDLE, S_VUP, S_P_CHK, S_E_CHK, S_FIN: begin
			end
		endcase
	end

	assign bus_start = (bus_wr || bus_rd) && !pend_q;
	assign tim_start = wt && !pend_q;
	assign step = cyc_done || tim_done;
	assign req_ready = (st_q == S_IDLE);
	assign rd_ok = (rd_data == dat_q);
	assign at_last = (addr_q == LAST_ADDR);
	assign program_supply_high = vpp_q;

	////////////////////////////////////////////////////////////////////////
	// Bus cycle engine; one cycle per command byte
	fpc_bus_cycle u_bus (
		.clk(clk),
		.rstn(rstn),
		.start(bus_start),
		.wr(bus_wr),
		.addr(addr_q),
		.wdata(wbyte),
		.dq_i(dq_i),
		.pins(pins),
		.rdata(rd_data),
		.done(cyc_done)
	);

	// Microsecond waits
	fpc_us_timer #(
		.CNT_W(US_W)
	) u_tim (
		.clk(clk),
		.rstn(rstn),
		.start(tim_start),
		.load_us(load_us),
		.done(tim_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Outstanding work flag, so each state launches exactly once
	always_ff @(posedge clk) begin
		if (!rstn || step) begin
			pend_q <= 1'b0;
		end else if (bus_start || tim_start) begin
			pend_q <= 1'b1;
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE: begin
					// Plain reads keep supply low, so no set-read is due
					if (req_valid) begin
						st_q <= (req.op == OP_READ) ? S_RD : S_VUP;
					end
				end
				S_VUP: begin
					// Two cycles of supply setup before select falls
					case (op_q)
						OP_SIG: st_q <= S_SIG_CMD;
						OP_PROG, OP_ERASE: st_q <= S_P_CMD;
						default: st_q <= S_A1;
					endcase
				end
				S_RD: if (step) st_q <= S_FIN;
				S_SIG_CMD: if (step) st_q <= S_SIG_RD;
				S_SIG_RD: if (step) st_q <= S_EXIT;
				S_P_CMD: if (step) st_q <= S_P_DAT;
				S_P_DAT: if (step) st_q <= S_P_WT; // Buses free once latched
				S_P_WT: if (step) st_q <= S_P_VCMD;
				S_P_VCMD: if (step) st_q <= S_P_RCV;
				S_P_RCV: if (step) st_q <= S_P_RD;
				S_P_RD: if (step) st_q <= S_P_CHK;
				S_P_CHK: begin
					if (rd_ok) begin
						if (op_q != OP_ERASE) begin
							st_q <= S_EXIT;
						end else begin
							// Fill pass done only at the last byte
							st_q <= at_last ? S_E_CMD1 : S_P_CMD;
						end
					end else begin
						// Give up after the last allowed attempt
						st_q <= (ploop_q == 5'(PROG_LOOPS - 1)) ? S_EXIT : S_P_CMD;
					end
				end
				S_E_CMD1: if (step) st_q <= S_E_CMD2;
				S_E_CMD2: if (step) st_q <= S_E_WT;
				S_E_WT: if (step) st_q <= S_E_VCMD;
				S_E_VCMD: if (step) st_q <= S_E_RCV;
				S_E_RCV: if (step) st_q <= S_E_RD;
				S_E_RD: if (step) st_q <= S_E_CHK;
				S_E_CHK: begin
					if (rd_data == BYTE_ERASED) begin
						st_q <= at_last ? S_EXIT : S_E_VCMD;
					end else begin
						st_q <= (eloop_q == 10'(MAX_ERASE - 1)) ? S_EXIT : S_E_CMD1;
					end
				end
				S_A1: if (step) st_q <= S_A2;
				S_A2: if (step) st_q <= S_FIN; // Flash is back in read
				S_EXIT: if (step) st_q <= S_FIN;
				S_FIN: st_q <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Operation, address and data latches
	always_ff @(posedge clk) begin
		if (!rstn) begin
			op_q <= OP_READ;
			addr_q <= '0;
			dat_q <= '0;
		end else if (st_q == S_IDLE && req_valid) begin
			op_q <= req.op;
			// Chip erase walks from the bottom, filling with zero
			addr_q <= (req.op == OP_ERASE) ? '0 : req.addr;
			dat_q <= (req.op == OP_ERASE) ? BYTE_PREPROG : req.data;
		end else if (st_q == S_P_CHK && rd_ok && op_q == OP_ERASE) begin
			// Verify pass restarts at the bottom after the fill
			addr_q <= at_last ? '0 : addr_q + 1'b1;
		end else if (st_q == S_E_CHK && rd_data == BYTE_ERASED && !at_last) begin
			// Re-erase keeps the failing address and resumes there
			addr_q <= addr_q + 1'b1;
		end
	end

	// Attempt counters
	always_ff @(posedge clk) begin
		if (!rstn || st_q == S_IDLE) begin
			ploop_q <= '0;
			eloop_q <= '0;
		end else if (st_q == S_P_CHK && (rd_ok || ploop_q != 5'(PROG_LOOPS - 1))) begin
			// Held at the last try, so the count never runs past the limit
			ploop_q <= rd_ok ? 5'h00 : ploop_q + 5'h01;
		end else if (st_q == S_E_CHK && rd_data != BYTE_ERASED) begin
			eloop_q <= eloop_q + 10'h001;
		end
	end

	// Failure flag: set when an attempt limit runs out
	always_ff @(posedge clk) begin
		if (!rstn || st_q == S_IDLE) begin
			fail_q <= 1'b0;
		end else if (st_q == S_P_CHK && !rd_ok && ploop_q == 5'(PROG_LOOPS - 1)) begin
			fail_q <= 1'b1;
		end else if (st_q == S_E_CHK && rd_data != BYTE_ERASED
				&& eloop_q == 10'(MAX_ERASE - 1)) begin
			fail_q <= 1'b1;
		end
	end

	// Program supply: high from a non-read request until S_FIN
	always_ff @(posedge clk) begin
		if (!rstn || st_q == S_FIN) begin
			vpp_q <= 1'b0;
		end else if (st_q == S_IDLE && req_valid && req.op != OP_READ) begin
			vpp_q <= 1'b1;
		end
	end

	// Answer, one pulse per request
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rsp_valid <= 1'b0;
			rsp <= '0;
		end else begin
			rsp_valid <= (st_q == S_FIN);
			if (st_q == S_FIN) begin
				rsp.data <= rd_data;
				rsp.fail <= fail_q;
			end
		end
	end

	// Helper for the checks: cycles in the present wait
	always_ff @(posedge clk) begin
		if (!rstn || !wt) begin
			wcnt_q <= '0;
		end else begin
			wcnt_q <= wcnt_q + 17'h00001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_cmd_vpp;
		@(posedge clk) disable iff (!rstn) bus_start && bus_wr |-> vpp_q;
	endproperty
	a_cmd_vpp: assert property (p_cmd_vpp) else $error("command with supply low");

	property p_prog_pair;
		@(posedge clk) disable iff (!rstn) st_q == S_P_CMD && step |=> st_q == S_P_DAT;
	endproperty
	a_prog_pair: assert property (p_prog_pair) else $error("program pair broken");

	sequence s_erase_first;
		st_q == S_E_CMD1 && step;
	endsequence
	property p_erase_pair;
		@(posedge clk) disable iff (!rstn) s_erase_first |=> st_q == S_E_CMD2 && bus_start;
	endproperty
	a_erase_pair: assert property (p_erase_pair) else $error("erase pair broken");

	property p_reset_pair;
		@(posedge clk) disable iff (!rstn) st_q == S_A1 && step |=> st_q == S_A2;
	endproperty
	a_reset_pair: assert property (p_reset_pair) else $error("reset pair broken");

	property p_prog_wait;
		@(posedge clk) disable iff (!rstn)
			st_q == S_P_WT && step |-> wcnt_q >= 17'(PROG_CYC - 1);
	endproperty
	a_prog_wait: assert property (p_prog_wait) else $error("program wait too short");

	property p_loop_cap;
		@(posedge clk) disable iff (!rstn) ploop_q < 5'(PROG_LOOPS);
	endproperty
	a_loop_cap: assert property (p_loop_cap) else $error("too many program tries");

	property p_exit_read;
		@(posedge clk) disable iff (!rstn)
			st_q == S_FIN && vpp_q |-> $past(st_q) == S_EXIT || $past(st_q) == S_A2;
	endproperty
	a_exit_read: assert property (p_exit_read) else $error("supply dropped outside read");

endmodule // fpc_ctrl

/* File: dv/fpc_flash_model.sv */
// Behavioural model of the byte-wide flash seen by the host controller
`timescale 1ns/10ps
module fpc_flash_model #(
	parameter int RD_DLY = 20, // Read access time in ns
	parameter logic [17:0] LAST_ADDR = 18'h3ffff, // Top of the pre-erase fill
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_ID = 8'h6b // Arbitrary value
) (
	input wire fpc_pkg::fpc_pins_t pins,
	input wire logic program_supply_high,
	output logic [7:0] dq_i
);
	import fpc_pkg::*;
	typedef enum logic [2:0] {
		M_READ, M_SIG, M_EVFY, M_PVFY, M_PROG2, M_ERS2, M_RST2
	} fpc_fm_mode_t;
	logic [7:0] mem [logic [17:0]]; // Absent entry reads as erased
	fpc_fm_mode_t mode_q = M_READ; // Power-up in array read
	logic [17:0] addr_fall = 18'h00000; // Address taken on strobe fall
	logic [17:0] addr_lat = 18'h00000; // Address used by verify reads
	logic [7:0] last_q = 8'h00; // Last byte seen on the wire
	logic [7:0] rd_byte; // Byte the flash would drive
	logic set_rd_q = 1'b0; // Set-read seen since the supply rose
	logic drv; // Flash drives the data lines
	int prog_cnt = 0;
	int erase_cnt = 0;
	int reset_cnt = 0;
	int bad = 0; // Host faults seen
	function automatic logic [7:0] peek(input logic [17:0] a);
		return mem.exists(a) ? mem[a] : BYTE_ERASED;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Output only with select low, drive low, strobe high
	assign drv = !pins.ce_n && !pins.oe_n && pins.we_n;
	always @* begin
		case (mode_q)
			M_SIG: rd_byte = pins.addr[0] ? PART_ID : MAKER_ID;
			M_EVFY, M_PVFY: rd_byte = peek(addr_lat);
			default: rd_byte = peek(pins.addr); // Full address
		endcase
	end
	// Released lines show the inverse of the last byte, so no stale value passes
	assign #RD_DLY dq_i = !pins.dq_oe_n ? pins.dq_o : (drv ? rd_byte : ~last_q);
	always @(posedge pins.ce_n) last_q <= dq_i;
	////////////////////////////////////////////////////////////////////////
	// Host faults: contention, or reads under high supply without set-read
	always @(posedge program_supply_high) set_rd_q = 1'b0;
	always @(negedge pins.oe_n) begin
		if (!pins.dq_oe_n) bad++;
		if (!pins.ce_n && program_supply_high && mode_q == M_READ && !set_rd_q) bad++;
	end
	always @(negedge pins.we_n) addr_fall = pins.addr;
	// Commands only with supply high, taken on the strobe rise
	always @(posedge pins.we_n) begin
		if (!pins.ce_n && program_supply_high) begin
			case (mode_q)
				M_PROG2: begin // Stop timer ends the pulse at once
					mem[addr_fall] = peek(addr_fall) & pins.dq_o;
					addr_lat = addr_fall;
					prog_cnt++;
					mode_q = M_READ;
				end
				M_ERS2: begin // Only a second erase code erases
					if (pins.dq_o == CMD_ERASE) begin
						foreach (mem[k]) if (k <= LAST_ADDR && mem[k] !== BYTE_PREPROG) bad++;
						mem.delete();
						erase_cnt++;
					end
					mode_q = M_READ;
				end
				M_RST2: begin // Second reset code aborts
					if (pins.dq_o == CMD_RESET) reset_cnt++;
					mode_q = M_READ;
				end
				default: begin // First cycle decode
					case (pins.dq_o)
						CMD_READ: set_rd_q = 1'b1;
						CMD_SIG: mode_q = M_SIG;
						CMD_ERASE: mode_q = M_ERS2;
						CMD_EVFY: addr_lat = addr_fall;
						CMD_PROG: mode_q = M_PROG2;
						CMD_PVFY: mode_q = M_PVFY;
						CMD_RESET: mode_q = M_RST2;
						default: mode_q = M_READ;
					endcase
					if (pins.dq_o == CMD_READ) mode_q = M_READ;
					if (pins.dq_o == CMD_EVFY) mode_q = M_EVFY;
				end
			endcase
		end
	end
endmodule // fpc_flash_model

/* File: dv/test_fpc_ctrl.sv */
// Self-checking bench of the flash host controller
`timescale 1ns/10ps
module test_fpc_ctrl;
	import fpc_pkg::*;
	localparam logic [17:0] LAST = 18'h00003; // Small erase sweep
	localparam logic [7:0] MK = 8'h5a; // Arbitrary value
	localparam logic [7:0] PT = 8'h6b; // Arbitrary value
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	logic req_ready;
	fpc_req_t req = '0;
	logic rsp_valid;
	fpc_rsp_t rsp;
	fpc_pins_t pins;
	logic [7:0] dq_i;
	logic program_supply_high;
	fpc_rsp_t got; // Last answer taken
	int errors = 0;
	int tests_run = 0;
	int base; // Model counter before a test
	always #50 clk = ~clk;
	fpc_ctrl #(.ERASE_US(3), .LAST_ADDR(LAST), .MAX_ERASE(4)) dut (
		.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_i(dq_i),
		.program_supply_high(program_supply_high)
	);
	// Slow reads, still inside the controller's sampling point
	fpc_flash_model #(.RD_DLY(150), .LAST_ADDR(LAST), .MAKER_ID(MK), .PART_ID(PT)) flash (
		.pins(pins), .program_supply_high(program_supply_high), .dq_i(dq_i)
	);
	////////////////////////////////////////////////////////////////////////
	// Verdict and compares
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic chk_flag(input string what, input logic exp, input logic seen);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic chk_cnt(input string what, input int exp, input int seen);
		tests_run++;
		if (seen != exp) begin
			errors++;
			$display("mismatch %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	// One request, held until taken, then a bounded wait for the answer
	task automatic do_req(input fpc_op_t op, input logic [17:0] a, input logic [7:0] d);
		int n;
		req_valid <= 1'b1;
		req <= '{op: op, addr: a, data: d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 100);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 20000);
		chk_flag("rsp_valid", 1'b1, rsp_valid);
		if (rsp_valid !== 1'b1) final_report();
		got = rsp;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		#1;
		chk_flag("ce_n", 1'b1, pins.ce_n);
		chk_flag("dq_oe_n", 1'b1, pins.dq_oe_n);
		chk_flag("supply", 1'b0, program_supply_high);
		chk_flag("req_ready", 1'b1, req_ready);
		$display("test reset done");
	endtask
	task automatic t_read();
		flash.mem[18'h2a5c3] = 8'h96;
		flash.mem[18'h0a5c3] = 8'h17;
		do_req(OP_READ, 18'h2a5c3, 8'h00);
		chk_byte("read top", 8'h96, got.data);
		do_req(OP_READ, 18'h0a5c3, 8'h00);
		chk_byte("read bit17 clear", 8'h17, got.data);
		do_req(OP_READ, 18'h1ffff, 8'h00);
		chk_byte("read blank", BYTE_ERASED, got.data);
		$display("test read done");
	endtask
	task automatic t_sig();
		do_req(OP_SIG, 18'h00000, 8'h00);
		chk_byte("maker code", MK, got.data);
		do_req(OP_SIG, 18'h00001, 8'h00);
		chk_byte("part code", PT, got.data);
		do_req(OP_READ, 18'h2a5c3, 8'h00);
		chk_byte("read after sig", 8'h96, got.data);
		$display("test sig done");
	endtask
	task automatic t_prog();
		base = flash.prog_cnt;
		do_req(OP_PROG, 18'h3fffe, 8'ha5);
		chk_flag("prog fail", 1'b0, got.fail);
		chk_cnt("prog pulses", base + 1, flash.prog_cnt);
		do_req(OP_READ, 18'h3fffe, 8'h00);
		chk_byte("prog readback", 8'ha5, got.data);
		// Bits cannot return to one, so every verify fails
		base = flash.prog_cnt;
		do_req(OP_PROG, 18'h3fffe, 8'h5a);
		chk_flag("prog limit fail", 1'b1, got.fail);
		chk_cnt("prog tries", base + PROG_LOOPS, flash.prog_cnt);
		do_req(OP_READ, 18'h3fffe, 8'h00);
		chk_byte("prog clear bits", 8'h00, got.data);
		$display("test prog done");
	endtask
	task automatic t_erase();
		for (int a = 0; a <= 3; a++) flash.mem[a] = 8'h3c + 8'(a);
		base = flash.erase_cnt;
		do_req(OP_ERASE, 18'h00000, 8'h00);
		chk_flag("erase fail", 1'b0, got.fail);
		chk_cnt("erase pulses", base + 1, flash.erase_cnt);
		for (int a = 0; a <= 4; a++) begin
			do_req(OP_READ, 18'(a), 8'h00);
			chk_byte("erased byte", BYTE_ERASED, got.data);
		end
		$display("test erase done");
	endtask
	task automatic t_abort();
		base = flash.reset_cnt;
		do_req(OP_ABORT, 18'h00000, 8'h00);
		chk_cnt("reset pairs", base + 1, flash.reset_cnt);
		do_req(OP_READ, 18'h3fffe, 8'h00);
		chk_byte("read after abort", BYTE_ERASED, got.data);
		$display("test abort done");
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		t_reset();
		@(posedge clk);
		rstn <= 1'b1;
		t_read();
		t_sig();
		t_prog();
		t_erase();
		t_abort();
		chk_cnt("host faults", 0, flash.bad);
		final_report();
	end
endmodule // test_fpc_ctrl
